/* File: verilog/ddcf_pkg.sv */
// shared constants, types and helpers of the down-conversion path
package ddcf_pkg;

  // ************************************************
  // widths and depths
  // ************************************************
  localparam int SAMP_W  = 14;
  localparam int DATA_W  = 20;
  localparam int ACC_W   = 25;
  localparam int FREQ_W  = 32;
  localparam int TRIG_W  = 12;
  localparam int FIFO_D  = 8;
  localparam int MIX_SH  = 5;
  localparam int SAMP_SH = 6;

  // ************************************************
  // register offsets and reset values
  // ************************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FREQ = 12'h004;
  localparam logic [11:0] ADDR_FMT  = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00c;
  localparam logic [11:0] ADDR_FACT = 12'h010;
  localparam logic [8:0]  CTRL_RST  = 9'h000;
  localparam logic [31:0] FREQ_RST  = 32'h0000_0000;
  localparam logic [4:0]  FMT_RST   = 5'h14;
  localparam int CTRL_RESTART_B = 7;

  // ************************************************
  // numeric limits and cosine quarter table
  // ************************************************
  localparam logic signed [26:0] SAT_MAX = 27'sh007ffff;
  localparam logic signed [26:0] SAT_MIN = 27'sh7f80000;
  localparam logic [4:0] RES_MIN = 5'h0e;
  localparam logic [4:0] RES_MAX = 5'h14;
  localparam logic [11:0] COS_T0 = 12'h7ff;
  localparam logic [11:0] COS_T1 = 12'h763;
  localparam logic [11:0] COS_T2 = 12'h5a7;
  localparam logic [11:0] COS_T3 = 12'h30f;

  typedef enum logic [1:0] {MODE_REAL, MODE_CPLX, MODE_REMIX, MODE_SPARE} ddcf_mode_t;

  typedef struct packed {
    logic       inv;
    logic       restart;
    logic       gain;
    logic [2:0] dec;
    ddcf_mode_t mode;
    logic       en;
  } ddcf_ctrl_t;

  typedef struct packed {
    logic        is_q;
    logic [19:0] data;
  } ddcf_word_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ddcf_apb_req_t;

  // number of low bits cleared for a given output resolution
  function automatic logic [4:0] ddcf_cut(input logic [4:0] res);
    if (res >= RES_MAX) ddcf_cut = 5'h00;
    else if (res < RES_MIN) ddcf_cut = RES_MAX - RES_MIN;
    else ddcf_cut = RES_MAX - res;
  endfunction : ddcf_cut

endpackage : ddcf_pkg

/* File: verilog/ddcf_fifo.sv */
// ready/valid word fifo between the filter and the output formatter
`timescale 1ns/1ns
`default_nettype none
module ddcf_fifo #(
  parameter int W = 21,
  parameter int D = 8
) (
  input  wire logic         mclk,      // sampling clock
  input  wire logic         rst_b,     // async reset
  input  wire logic         ce,        // clock enable
  input  wire logic         in_valid,  // word offered
  output logic              in_ready,  // room for a word
  input  wire logic [W-1:0] in_data,   // word in
  output logic              out_valid, // word available
  input  wire logic         out_ready, // drain accepts
  output logic [W-1:0]      out_data,  // word out
  output logic [$clog2(D):0] level     // words held
);
  localparam int PW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wp;
    logic [PW-1:0]       rp;
    logic [PW:0]         cnt;
  } ddcf_fifo_st_t;

  ddcf_fifo_st_t q, d;
  logic push, pop;

  // ************************************************
  // handshake: frozen clock enable stalls both sides
  // ************************************************
  assign in_ready  = ce && (q.cnt != (PW+1)'(D));
  assign out_valid = ce && (q.cnt != '0);
  assign out_data  = q.mem[q.rp];
  assign level     = q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (pop) d.rp = q.rp + 1'b1;
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) q <= '0;
    else if (ce) q <= d;
  end

  // ************************************************
  // checks
  // ************************************************
  chk_fifo_level: assert property (@(posedge mclk) disable iff (!rst_b)
    push && !pop |=> level == $past(level) + 1'b1)
    else $error("fifo level did not grow on push");
  cover_fifo_full: cover property (@(posedge mclk) disable iff (!rst_b)
    ce && !in_ready);

endmodule : ddcf_fifo
`default_nettype wire

/* File: verilog/ddcf_nco.sv */
// numerically controlled oscillator with restart and pending frequency load
`timescale 1ns/1ns
`default_nettype none
module ddcf_nco import ddcf_pkg::*; (
  input  wire logic              mclk,      // sampling clock
  input  wire logic              rst_b,     // async reset
  input  wire logic              ce,        // clock enable
  input  wire logic              step,      // advance one sample
  input  wire logic              load,      // restart event
  input  wire logic [FREQ_W-1:0] freq_pend, // software frequency word
  output logic [FREQ_W-1:0]      freq_act,  // frequency in use
  output logic [FREQ_W-1:0]      phase,     // accumulated phase
  output logic signed [TRIG_W-1:0] cos_v,   // cosine of phase
  output logic signed [TRIG_W-1:0] sin_v    // sine of phase
);
  typedef struct packed {
    logic [FREQ_W-1:0] freq;
    logic [FREQ_W-1:0] ph;
    logic [TRIG_W-1:0] c;
    logic [TRIG_W-1:0] s;
  } ddcf_nco_st_t;

  ddcf_nco_st_t q, d;

  // sixteen-step cosine; coarse, but spurs stay below the filter floor for tests
  function automatic logic [TRIG_W-1:0] ddcf_cos(input logic [3:0] k);
    logic [1:0] i;
    logic [TRIG_W-1:0] m;
    i = k[1:0];
    if (k[2]) i = 2'h0 - k[1:0];
    case (i)
      2'h0: m = (k[2] && k[1:0] == 2'h0) ? COS_T0 : COS_T0;
      2'h1: m = COS_T1;
      2'h2: m = COS_T2;
      default: m = COS_T3;
    endcase
    if (k[1:0] == 2'h0 && k[2]) m = 12'h000;
    if (k[3] ^ (k[2] && k[1:0] != 2'h0)) m = 12'h000 - m;
    ddcf_cos = m;
  endfunction : ddcf_cos

  assign freq_act = q.freq;
  assign phase    = q.ph;
  assign cos_v    = $signed(q.c);
  assign sin_v    = $signed(q.s);

  // ************************************************
  // phase accumulator, signed step wraps modulo a full turn
  // ************************************************
  always_comb begin
    d = q;
    if (load) begin
      d.freq = freq_pend;
      d.ph   = '0;
    end else if (step) begin
      d.ph = q.ph + q.freq;
    end
    d.c = ddcf_cos(d.ph[31:28]);
    d.s = ddcf_cos(d.ph[31:28] - 4'h4);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) q <= '{freq: FREQ_RST, ph: '0, c: COS_T0, s: 12'h000};
    else if (ce) q <= d;
  end

endmodule : ddcf_nco
`default_nettype wire

/* File: verilog/ddcf_top.sv */
// down-conversion path: mixer, decimator, gain, truncation, fifo and apb slave
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module ddcf_top import ddcf_pkg::*; (
  input  wire logic              mclk,        // sampling clock
  input  wire logic              rst_b,       // async reset
  input  wire logic              ce,          // clock enable
  input  wire ddcf_apb_req_t     apb_req,     // apb request group
  output logic                   pready,      // apb ready
  output logic [31:0]            prdata,      // apb read data
  output logic                   pslverr,     // apb error
  input  wire logic              align_pin,   // powerdown_or_align_pin
  input  wire logic [SAMP_W-1:0] adc_sample,  // converter sample
  input  wire logic              adc_valid,   // sample offered
  output logic                   adc_ready,   // sample accepted
  output logic                   out_valid,   // word available
  input  wire logic              out_ready,   // formatter accepts
  output logic [DATA_W-1:0]      out_data,    // formatted word
  output logic                   out_is_q     // word is quadrature
);
  typedef struct packed {
    ddcf_ctrl_t         ctrl;
    logic [31:0]        freq;
    logic [4:0]         res;
    logic [31:0]        prdata;
    logic               perr;
    logic               sync1;
    logic               sync2;
    logic               sync3;
    logic [4:0]         cnt;
    logic signed [24:0] acc_i;
    logic signed [24:0] acc_q;
    logic               pend_q;
    ddcf_word_t         hold;
    logic               pair;
  } ddcf_st_t;

  ddcf_st_t q, d;

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic ddcf_addr_ok(input logic [11:0] a);
    ddcf_addr_ok = (a == ADDR_CTRL) || (a == ADDR_FREQ) || (a == ADDR_FMT)
                || (a == ADDR_STAT) || (a == ADDR_FACT);
  endfunction : ddcf_addr_ok

  // gain, saturation and truncation of one filter result
  function automatic logic [DATA_W-1:0] ddcf_finish(input logic signed [24:0] x,
      input logic gain, input logic real_m, input logic [4:0] res);
    logic signed [26:0] g;
    logic [DATA_W-1:0]  s;
    logic [4:0]         cut;
    g = {{2{x[24]}}, x};
    cut = ddcf_cut(res);
    if (gain && real_m) g = g + (g >>> 2) + (g >>> 3) + (g >>> 5);
    else if (gain) g = g <<< 1;
    if (g > SAT_MAX) s = 20'h7ffff;
    else if (g < SAT_MIN) s = 20'h80000;
    else s = g[19:0];
    ddcf_finish = s & ~((20'h00001 << cut) - 20'h00001);
  endfunction : ddcf_finish

  logic                     setup, access, wr, ctrl_wr, ctrl_ev, pin_ev, restart;
  logic                     real_m, remix_m, in_fire, push, step;
  logic                     fifo_rdy;
  logic [3:0]               fifo_lvl;
  logic [2:0]               sh;
  logic [4:0]               last;
  logic signed [SAMP_W-1:0] samp;
  logic signed [19:0]       samp20;
  logic signed [TRIG_W-1:0] cos_v, sin_v, sin_m;
  logic signed [25:0]       prod_i, prod_q;
  logic signed [19:0]       mi, mq;
  logic signed [24:0]       sum_i, sum_q, si, sq;
  logic [31:0]              freq_act, nco_ph;
  ddcf_word_t               push_word, fifo_out;

  // ************************************************
  // combinational datapath terms
  // ************************************************
  assign setup   = apb_req.psel && !apb_req.penable;
  assign access  = apb_req.psel && apb_req.penable;
  assign wr      = ce && access && apb_req.pwrite && ddcf_addr_ok(apb_req.paddr);
  assign ctrl_wr = wr && (apb_req.paddr == ADDR_CTRL);
  assign ctrl_ev = ctrl_wr && (apb_req.pwdata[CTRL_RESTART_B] != q.ctrl.restart);
  assign pin_ev  = q.sync2 ^ q.sync3;
  assign restart = ctrl_ev || pin_ev;
  assign real_m  = (q.ctrl.mode == MODE_REAL);
  assign remix_m = (q.ctrl.mode == MODE_REMIX);
  assign adc_ready = fifo_rdy && !q.pend_q;
  assign in_fire = adc_valid && adc_ready;
  assign step    = in_fire && q.ctrl.en && !real_m;
  assign sh      = (q.ctrl.dec >= 3'h4) ? 3'h5 : q.ctrl.dec + 3'h1;
  assign last    = 5'((6'h01 << sh) - 6'h01);
  assign samp    = $signed(adc_sample);
  assign samp20  = {samp, 6'h00};
  assign sin_m   = q.ctrl.inv ? -sin_v : sin_v;
  assign prod_i  = 26'(samp) * 26'(cos_v);
  assign prod_q  = 26'(samp) * 26'(sin_m);
  assign mi      = real_m ? samp20 : prod_i[24:5];
  assign mq      = real_m ? 20'sh00000 : prod_q[24:5];
  assign sum_i   = q.acc_i + {{5{mi[19]}}, mi};
  assign sum_q   = q.acc_q + {{5{mq[19]}}, mq};
  assign si      = sum_i >>> sh;
  assign sq      = sum_q >>> sh;

  // apb answers without wait states while enabled
  assign pready   = ce;
  assign prdata   = q.prdata;
  assign pslverr  = access && q.perr;
  assign out_data = fifo_out.data;
  assign out_is_q = fifo_out.is_q;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    d = q;
    push = 1'b0;
    push_word = '0;
    // pin synchroniser, first flop feeds only the second
    d.sync1 = align_pin;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    // register read captured in setup, error flagged for unmapped words
    if (setup) begin
      d.perr = !ddcf_addr_ok(apb_req.paddr);
      if (apb_req.paddr == ADDR_CTRL) d.prdata = {23'h000000, q.ctrl};
      else if (apb_req.paddr == ADDR_FREQ) d.prdata = q.freq;
      else if (apb_req.paddr == ADDR_FMT) d.prdata = {27'h0000000, q.res};
      else if (apb_req.paddr == ADDR_STAT) d.prdata = {26'h0, !fifo_rdy, fifo_lvl, q.ctrl.en};
      else if (apb_req.paddr == ADDR_FACT) d.prdata = freq_act;
      else d.prdata = 32'h0000_0000;
    end
    if (ctrl_wr) d.ctrl = ddcf_ctrl_t'(apb_req.pwdata[8:0]);
    else if (wr && apb_req.paddr == ADDR_FREQ) d.freq = apb_req.pwdata;
    else if (wr && apb_req.paddr == ADDR_FMT) d.res = apb_req.pwdata[4:0];
    // second word of a complex pair goes out before new input
    if (q.pend_q && fifo_rdy) begin
      push = 1'b1;
      push_word = q.hold;
      d.pend_q = 1'b0;
    end else if (in_fire && !q.ctrl.en) begin
      push = 1'b1;
      push_word = '{is_q: 1'b0, data: ddcf_finish({{5{samp20[19]}}, samp20}, 1'b0, 1'b1, q.res)};
    end else if (in_fire && q.cnt == last) begin
      push = 1'b1;
      d.cnt = 5'h00;
      d.acc_i = '0;
      d.acc_q = '0;
      d.pend_q = !real_m;
      if (real_m) begin
        push_word = '{is_q: 1'b0, data: ddcf_finish(si, q.ctrl.gain, 1'b1, q.res)};
      end else if (remix_m) begin
        // quarter-rate rotation: I, -Q, then -I, Q on the next pair
        d.pair = !q.pair;
        push_word = '{is_q: 1'b0,
                      data: ddcf_finish(q.pair ? -si : si, q.ctrl.gain, 1'b0, q.res)};
        d.hold = '{is_q: 1'b0,
                   data: ddcf_finish(q.pair ? sq : -sq, q.ctrl.gain, 1'b0, q.res)};
      end else begin
        push_word = '{is_q: 1'b0, data: ddcf_finish(si, q.ctrl.gain, 1'b0, q.res)};
        d.hold = '{is_q: 1'b1, data: ddcf_finish(sq, q.ctrl.gain, 1'b0, q.res)};
      end
    end else if (in_fire) begin
      d.cnt = q.cnt + 5'h01;
      d.acc_i = sum_i;
      d.acc_q = sum_q;
    end
    // alignment event restarts the divider and drops a half-sent pair
    if (restart) begin
      d.cnt = 5'h00;
      d.acc_i = '0;
      d.acc_q = '0;
      d.pend_q = 1'b0;
      d.pair = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.ctrl <= ddcf_ctrl_t'(CTRL_RST);
      q.freq <= FREQ_RST;
      q.res <= FMT_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // ************************************************
  // oscillator and output buffer
  // ************************************************
  ddcf_nco u_nco (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .ce        (ce),
    .step      (step),
    .load      (restart),
    .freq_pend (q.freq),
    .freq_act  (freq_act),
    .phase     (nco_ph),
    .cos_v     (cos_v),
    .sin_v     (sin_v)
  );

  ddcf_fifo #(.W(DATA_W + 1), .D(FIFO_D)) u_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .in_data   (push_word),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out),
    .level     (fifo_lvl)
  );

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  chk_enable_write: assert property (
    ce && $changed(q.ctrl.en) |-> $past(ctrl_wr))
    else $error("enable changed without a control write");
  chk_freq_hold: assert property (
    ce && !restart |=> $stable(freq_act))
    else $error("active frequency changed without restart");
  chk_restart_load: assert property (
    ce && restart |=> nco_ph == 32'h0 && freq_act == $past(q.freq) && q.cnt == 5'h00)
    else $error("restart did not clear phase and load frequency");
  chk_pass_thru: assert property (
    in_fire && !q.ctrl.en && !q.pend_q |-> push && push_word.data[19:6] == adc_sample)
    else $error("disabled path did not pass the raw sample");
  chk_trunc_low: assert property (
    push |-> (push_word.data & ((20'h00001 << ddcf_cut(q.res)) - 20'h00001)) == 20'h0)
    else $error("bits below the output resolution not cleared");
  chk_dec_count: assert property (
    push && q.ctrl.en && !q.pend_q |-> q.cnt == last && in_fire)
    else $error("decimated word not on the last input of a block");
  chk_q_second: assert property (
    ce && push && q.ctrl.en && !q.pend_q && q.ctrl.mode == MODE_CPLX && !restart
      |=> q.pend_q && q.hold.is_q)
    else $error("complex result lacks its quadrature word");
  chk_real_single: assert property (
    ce && push && q.ctrl.en && !q.pend_q && real_m |=> !q.pend_q)
    else $error("real mode produced a second word");
  chk_remix_real: assert property (
    push && q.ctrl.en && remix_m |-> !push_word.is_q)
    else $error("remix mode emitted a quadrature word");

  cover_cplx_pair: cover property (push && q.pend_q && q.hold.is_q);
  cover_remix_out: cover property (push && q.ctrl.en && remix_m && q.pair);
  cover_pin_align: cover property (pin_ev && q.ctrl.en);

endmodule : ddcf_top
`default_nettype wire

/* File: bench/ddcf_capture.sv */
// capture model of the formatter side, with a stall control
`timescale 1ns/1ns
`default_nettype none
module ddcf_capture import ddcf_pkg::*; (
  input  wire logic              mclk,      // sampling clock
  input  wire logic              stall,     // hold off accepting
  input  wire logic              out_valid, // word offered
  input  wire logic [DATA_W-1:0] out_data,  // word
  input  wire logic              out_is_q,  // quadrature flag
  output var logic               out_ready  // model accepts
);
  ddcf_word_t got[$];

  // ready lags stall by one edge, as a registered sink would
  always @(posedge mclk) begin
    out_ready <= !stall;
    if (out_valid && out_ready) begin
      got.push_back('{is_q: out_is_q, data: out_data});
    end
  end
endmodule : ddcf_capture
`default_nettype wire

/* File: bench/ddcf_top_tb.sv */
// self-checking bench of the down-conversion path
`timescale 1ns/1ns
`default_nettype none
module ddcf_top_tb import ddcf_pkg::*; ;
  logic              mclk, rst_b, ce, align_pin, adc_valid, stall, rs, err;
  logic              pready, pslverr, adc_ready, out_valid, out_ready, out_is_q;
  logic [SAMP_W-1:0] adc_sample;
  logic [DATA_W-1:0] out_data;
  logic [31:0]       prdata, rd;
  ddcf_apb_req_t     apb_req;
  int                fails, checks_done;

  ddcf_top dut_u (.mclk(mclk), .rst_b(rst_b), .ce(ce), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .align_pin(align_pin), .adc_sample(adc_sample),
    .adc_valid(adc_valid), .adc_ready(adc_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_is_q(out_is_q));
  ddcf_capture cap_u (.mclk(mclk), .stall(stall), .out_valid(out_valid),
    .out_data(out_data), .out_is_q(out_is_q), .out_ready(out_ready));

  // ************************************************
  // common tasks
  // ************************************************
  task automatic stop_test;
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask : apb

  // every control write flips restart, so each one realigns the dividers
  task automatic ctrl(input logic [1:0] m, input logic [2:0] dec, input logic g, input logic en);
    rs = ~rs;
    apb(1'b1, ADDR_CTRL, {23'h0, 1'b0, rs, g, dec, m, en});
    cap_u.got.delete();
  endtask : ctrl

  task automatic send(input logic [SAMP_W-1:0] s, input int n);
    repeat (n) begin
      adc_sample <= s;
      adc_valid <= 1'b1;
      do @(posedge mclk); while (adc_ready !== 1'b1);
    end
    adc_valid <= 1'b0;
    @(posedge mclk);
  endtask : send

  // bounded wait, then a quiet spell so extra words would show up
  task automatic expect_words(input int n);
    int k;
    k = 0;
    while (cap_u.got.size() < n && k < 400) begin
      @(posedge mclk);
      k++;
    end
    repeat (20) @(posedge mclk);
    check(32'(cap_u.got.size()), 32'(n), "word count");
  endtask : expect_words

  task automatic word(input int i, input logic q, input logic [DATA_W-1:0] d);
    check(32'({cap_u.got[i].is_q, cap_u.got[i].data}), 32'({q, d}), "word");
  endtask : word

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_reset;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'(CTRL_RST), "ctrl reset");
    apb(1'b0, ADDR_FMT, 32'h0);
    check(rd, 32'(FMT_RST), "fmt reset");
    apb(1'b0, 12'h020, 32'h0);
    check({rd[30:0], err}, 32'h1, "unmapped read");
  endtask : t_reset

  task automatic t_pass;
    cap_u.got.delete();
    send(14'h1fff, 1);
    send(14'h2000, 1);
    expect_words(2);
    word(0, 1'b0, 20'h7ffc0);
    word(1, 1'b0, 20'h80000);
  endtask : t_pass

  // frequency is still zero here, though real mode bypasses the mixer and never steps the oscillator
  task automatic t_real;
    for (int d = 0; d < 5; d++) begin
      ctrl(MODE_REAL, 3'(d), 1'b0, 1'b1);
      send(14'd100, 32);
      expect_words(32 >> (d + 1));
      word(0, 1'b0, 20'd6400);
    end
    // 3-dB gain: 6400 scaled by 1.40625
    ctrl(MODE_REAL, 3'h0, 1'b1, 1'b1);
    send(14'd100, 2);
    expect_words(1);
    word(0, 1'b0, 20'd9000);
  endtask : t_real

  task automatic t_cplx;
    ddcf_mode_t m[2];
    m = '{MODE_CPLX, MODE_SPARE};
    foreach (m[i]) begin
      ctrl(m[i], 3'h0, 1'b0, 1'b1);
      send(14'd100, 4);
      expect_words(4);
      word(0, 1'b0, 20'd6396);
      word(1, 1'b1, 20'd0);
    end
    ctrl(MODE_CPLX, 3'h0, 1'b1, 1'b1);
    send(14'd100, 2);
    expect_words(2);
    word(0, 1'b0, 20'd12792);
    apb(1'b1, ADDR_FMT, 32'd16);
    ctrl(MODE_CPLX, 3'h0, 1'b0, 1'b1);
    send(14'd100, 2);
    expect_words(2);
    word(0, 1'b0, 20'd6384);
    apb(1'b1, ADDR_FMT, 32'd20);
  endtask : t_cplx

  task automatic t_remix;
    ctrl(MODE_REMIX, 3'h0, 1'b0, 1'b1);
    send(14'd100, 4);
    expect_words(4);
    word(0, 1'b0, 20'd6396);
    word(1, 1'b0, 20'd0);
    word(2, 1'b0, -20'sd6396);
    word(3, 1'b0, 20'd0);
  endtask : t_remix

  task automatic t_freq;
    apb(1'b1, ADDR_FREQ, 32'h8000_0000);
    apb(1'b0, ADDR_FACT, 32'h0);
    check(rd, 32'h0, "freq before restart");
    ctrl(MODE_REAL, 3'h0, 1'b0, 1'b1);
    apb(1'b0, ADDR_FACT, 32'h0);
    check(rd, 32'h8000_0000, "freq after restart");
    apb(1'b1, ADDR_FREQ, 32'h1);
    align_pin <= ~align_pin;
    repeat (6) @(posedge mclk);
    apb(1'b0, ADDR_FACT, 32'h0);
    check(rd, 32'h1, "freq after pin");
    apb(1'b1, ADDR_FREQ, 32'h0);
  endtask : t_freq

  // fill the buffer while the sink stalls, then drain it in order
  task automatic t_fifo;
    ctrl(MODE_REAL, 3'h0, 1'b0, 1'b0);
    stall <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int i = 1; i < 9; i++) send(14'(i), 1);
    adc_sample <= 14'd9;
    adc_valid <= 1'b1;
    @(posedge mclk);
    check(32'(adc_ready), 32'h0, "ready when full");
    adc_valid <= 1'b0;
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rd, 32'h30, "full status");
    stall <= 1'b0;
    expect_words(8);
    for (int i = 1; i < 9; i++) word(i - 1, 1'b0, 20'(i << 6));
  endtask : t_fifo

  // a low clock enable must hold off both the slave and the sample port
  task automatic t_ce;
    ce <= 1'b0;
    @(posedge mclk);
    check({30'h0, pready, adc_ready}, 32'h0, "handshakes with ce low");
    ce <= 1'b1;
    @(posedge mclk);
    check({30'h0, pready, adc_ready}, 32'h3, "handshakes with ce high");
  endtask : t_ce

  // ************************************************
  // clock, reset, sequence and watchdog
  // ************************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    align_pin = 1'b0;
    adc_valid = 1'b0;
    adc_sample = '0;
    stall = 1'b0;
    apb_req = '0;
    rs = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_pass();
    t_real();
    t_cplx();
    t_remix();
    t_freq();
    t_fifo();
    t_ce();
    stop_test();
  end

  // far longer than the whole sequence needs
  initial begin
    #500000;
    fails++;
    stop_test();
  end
endmodule : ddcf_top_tb
`default_nettype wire
